//--- rtl/mah_pkg.sv
package mah_pkg;

  // Register offsets on the management bus
  localparam logic [7:0] MAH_ADDR_MASK_ONE = 8'h74;
  localparam logic [7:0] MAH_ADDR_MASK_TWO = 8'h75;
  localparam logic [7:0] MAH_ADDR_HOT_STATUS = 8'h79;
  localparam logic [7:0] MAH_ADDR_HOT_LIMIT_MASK = 8'h7A;
  localparam logic [7:0] MAH_ADDR_PULSES = 8'h7B;
  localparam logic [7:0] MAH_ADDR_TEST_ONE = 8'h7E;
  localparam logic [7:0] MAH_ADDR_TEST_TWO = 8'h7F;
  localparam logic [7:0] MAH_ADDR_LOW_VOLTS = 8'h76;
  localparam logic [7:0] MAH_ADDR_LOW_TEMPS = 8'h77;
  localparam logic [7:0] MAH_ADDR_PIN_TACH_CFG = 8'h78;

  // Most-significant-byte result registers whose reads release a freeze
  localparam logic [7:0] MAH_ADDR_MSB_2V5 = 8'h20;
  localparam logic [7:0] MAH_ADDR_MSB_PROC = 8'h21;
  localparam logic [7:0] MAH_ADDR_MSB_OWN = 8'h22;
  localparam logic [7:0] MAH_ADDR_MSB_5V = 8'h23;
  localparam logic [7:0] MAH_ADDR_MSB_12V = 8'h24;
  localparam logic [7:0] MAH_ADDR_MSB_REM1 = 8'h25;
  localparam logic [7:0] MAH_ADDR_MSB_LOCAL = 8'h26;
  localparam logic [7:0] MAH_ADDR_MSB_REM2 = 8'h27;

  // Reset values
  localparam logic [7:0] MAH_RST_MASK = 8'h00;
  localparam logic [7:0] MAH_RST_HOT = 8'h00;
  localparam logic [7:0] MAH_RST_PULSES = 8'h55;
  localparam logic [7:0] MAH_RST_TEST = 8'h00;
  localparam logic [7:0] MAH_RST_CFG = 8'h00;

  // Field positions
  localparam int MAH_M2_FAN4_HOT = 5;
  localparam int MAH_M2_OVERTEMP = 1;
  localparam int MAH_M1_ALL_TWO = 7;
  localparam int MAH_CFG_ALERT = 0;
  localparam int MAH_CFG_HOT_SEL = 1;
  localparam int MAH_CFG_BOOST = 2;
  localparam int MAH_CFG_FAST = 3;
  localparam int MAH_CFG_CONT_LO = 4;
  localparam int MAH_HOT_RELEASE = 6;
  localparam int MAH_HOT_ASSERT = 7;
  localparam int MAH_TIMER_W = 6;
  localparam logic [5:0] MAH_TIMER_MAX = 6'h3F;

  // Timing
  localparam int MAH_CLOCK_MHZ = 125;
  localparam int MAH_HOT_STEP_MS = 125;
  localparam int MAH_HOT_STEP_CYCLES = MAH_HOT_STEP_MS * 1000 * MAH_CLOCK_MHZ;
  localparam int MAH_TACH_FAST_MS = 250;
  localparam int MAH_TACH_SLOW_MS = 1000;
  localparam logic [3:0] MAH_TACH_FAST_STEPS = 4'(MAH_TACH_FAST_MS / MAH_HOT_STEP_MS);
  localparam logic [3:0] MAH_TACH_SLOW_STEPS = 4'(MAH_TACH_SLOW_MS / MAH_HOT_STEP_MS);

  typedef enum logic [1:0] {
    MAH_HOT_IDLE = 2'h1,
    MAH_HOT_ON = 2'h2
  } mah_hot_state_type;

  typedef struct packed {
    logic full_speed;
    logic fast_tach;
    logic [3:0] continuous_tach;
    logic tach_strobe;
  } mah_fan_ctrl_type;

endpackage : mah_pkg

//--- rtl/mah_regs.sv
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
module mah_regs #(
  parameter int HOT_STEP_CYCLES = mah_pkg::MAH_HOT_STEP_CYCLES
) (
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic config_lock_in,
  input wire logic [7:0] low_bits_volts_in,
  input wire logic [7:0] low_bits_temps_in,
  output logic [1:0] freeze_out,
  input wire logic [6:0] status_one_in,
  input wire logic [7:0] status_two_in,
  input wire logic fourth_tach_pin_in,
  input wire logic pwm_two_drive_in,
  output logic alert_pin_out,
  output logic alert_pin_oe_n_out,
  output logic alert_active_out,
  output logic hot_limit_exceeded_out,
  output mah_pkg::mah_fan_ctrl_type fan_ctrl_out,
  output logic [7:0] pulses_per_rev_out,
  output logic [7:0] factory_test_one_out,
  output logic [7:0] factory_test_two_out
);
  import mah_pkg::*;

  localparam int STEP_W = $clog2(HOT_STEP_CYCLES + 1);
  localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(HOT_STEP_CYCLES - 1);

  logic [7:0] mask_one_ff;
  logic [7:0] mask_two_ff;
  logic [7:0] limit_mask_ff;
  logic [7:0] pulses_ff;
  logic [7:0] test_one_ff;
  logic [7:0] test_two_ff;
  logic [7:0] cfg_ff;
  logic [7:0] rdata_ff;
  logic hot_release_flag_ff;
  logic hot_assert_flag_ff;
  logic [MAH_TIMER_W-1:0] hot_duration_timer_ff;
  logic [STEP_W-1:0] hot_step_ff;
  logic hot_exceeded_ff;
  logic hot_limit_pulse_ff;
  mah_hot_state_type hot_state_ff;
  logic [STEP_W-1:0] tach_step_ff;
  logic [3:0] tach_ticks_ff;
  logic tach_strobe_ff;
  logic pin_drive_low_ff;
  logic wr_hit;
  logic rd_hit;

  assign wr_hit = reg_wr_in;
  assign rd_hit = reg_rd_in;

  //////////////////////////////////////////////////////////////////////////////
  // Writable registers

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mask_one_ff <= MAH_RST_MASK;
      mask_two_ff <= MAH_RST_MASK;
      limit_mask_ff <= MAH_RST_HOT;
      pulses_ff <= MAH_RST_PULSES;
      cfg_ff <= MAH_RST_CFG;
    end else if (wr_hit) begin
      if (reg_addr_in == MAH_ADDR_MASK_ONE) begin
        // Top bit is read-only and stays clear
        mask_one_ff <= {1'b0, reg_wdata_in[MAH_M1_ALL_TWO-1:0]};
      end else if (reg_addr_in == MAH_ADDR_MASK_TWO) begin
        mask_two_ff <= reg_wdata_in;
        mask_two_ff[MAH_M2_OVERTEMP] <= 1'b0;
      end else if (reg_addr_in == MAH_ADDR_HOT_LIMIT_MASK) begin
        limit_mask_ff <= reg_wdata_in;
      end else if (reg_addr_in == MAH_ADDR_PULSES) begin
        pulses_ff <= reg_wdata_in;
      end else if (reg_addr_in == MAH_ADDR_PIN_TACH_CFG) begin
        cfg_ff <= reg_wdata_in;
      end
    end
  end

  // Factory test storage, sealed by the lock
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      test_one_ff <= MAH_RST_TEST;
      test_two_ff <= MAH_RST_TEST;
    end else if (wr_hit && !config_lock_in) begin
      if (reg_addr_in == MAH_ADDR_TEST_ONE) begin
        test_one_ff <= reg_wdata_in;
      end else if (reg_addr_in == MAH_ADDR_TEST_TWO) begin
        test_two_ff <= reg_wdata_in;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Low-bit readback with freeze

  logic [7:0] low_live [2];
  logic [7:0] low_addr [2];
  logic [7:0] low_hold [2];
  logic [7:0] msb_addr [2][4];

  assign low_live[0] = low_bits_volts_in;
  assign low_live[1] = low_bits_temps_in;
  assign low_addr[0] = MAH_ADDR_LOW_VOLTS;
  assign low_addr[1] = MAH_ADDR_LOW_TEMPS;
  assign msb_addr[0] = '{MAH_ADDR_MSB_2V5, MAH_ADDR_MSB_PROC, MAH_ADDR_MSB_OWN, MAH_ADDR_MSB_5V};
  assign msb_addr[1] = '{MAH_ADDR_MSB_12V, MAH_ADDR_MSB_REM1, MAH_ADDR_MSB_LOCAL,
                         MAH_ADDR_MSB_REM2};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_low
      logic [7:0] hold_ff;
      logic [3:0] pend_ff;
      logic frozen_ff;
      logic [3:0] msb_read;
      logic self_read;

      assign self_read = rd_hit && (reg_addr_in == low_addr[g]);
      for (genvar k = 0; k < 4; k++) begin : gen_msb
        assign msb_read[k] = rd_hit && (reg_addr_in == msb_addr[g][k]);
      end

      // Hold on the read edge itself so the value returned is the one kept
      always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          hold_ff <= 8'h00;
        end else if (!(frozen_ff || self_read)) begin
          hold_ff <= low_live[g];
        end
      end

      always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          pend_ff <= 4'h0;
          frozen_ff <= 1'b0;
        end else if (self_read) begin
          pend_ff <= 4'hF;
          frozen_ff <= 1'b1;
        end else if (frozen_ff) begin
          pend_ff <= pend_ff & ~msb_read;
          frozen_ff <= |(pend_ff & ~msb_read);
        end
      end

      assign low_hold[g] = hold_ff;
      assign freeze_out[g] = frozen_ff;
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Processor-hot tracking

  logic hot_active;
  logic hot_rise;
  logic hot_fall;
  logic status_read;

  // Pin is active low and only counts when selected
  assign hot_active = cfg_ff[MAH_CFG_HOT_SEL] && !fourth_tach_pin_in;
  assign hot_rise = hot_active && (hot_state_ff == MAH_HOT_IDLE);
  assign hot_fall = !hot_active && (hot_state_ff == MAH_HOT_ON);
  assign status_read = rd_hit && (reg_addr_in == MAH_ADDR_HOT_STATUS);

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hot_state_ff <= MAH_HOT_IDLE;
    end else begin
      case (hot_state_ff)
        MAH_HOT_IDLE: begin
          if (hot_active) begin
            hot_state_ff <= MAH_HOT_ON;
          end
        end
        MAH_HOT_ON: begin
          if (!hot_active) begin
            hot_state_ff <= MAH_HOT_IDLE;
          end
        end
        default: begin
          hot_state_ff <= MAH_HOT_IDLE;
        end
      endcase
    end
  end

  // Event beats the clear-on-read
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hot_release_flag_ff <= 1'b0;
      hot_assert_flag_ff <= 1'b0;
    end else begin
      if (hot_fall) begin
        hot_release_flag_ff <= 1'b1;
      end else if (status_read) begin
        hot_release_flag_ff <= 1'b0;
      end
      if (hot_rise) begin
        hot_assert_flag_ff <= 1'b1;
      end else if (status_read) begin
        hot_assert_flag_ff <= 1'b0;
      end
    end
  end

  // Timer restarts at each new assertion and keeps its value after release
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hot_step_ff <= '0;
      hot_duration_timer_ff <= '0;
    end else if (hot_rise) begin
      hot_step_ff <= '0;
      hot_duration_timer_ff <= '0;
    end else if (hot_state_ff == MAH_HOT_ON && hot_active) begin
      if (hot_step_ff == STEP_LAST) begin
        hot_step_ff <= '0;
        if (hot_duration_timer_ff != MAH_TIMER_MAX) begin
          hot_duration_timer_ff <= hot_duration_timer_ff + 6'h01;
        end
      end else begin
        hot_step_ff <= hot_step_ff + STEP_W'(1);
      end
    end
  end

  // One pulse per assertion that outlasts the limit
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hot_exceeded_ff <= 1'b0;
      hot_limit_pulse_ff <= 1'b0;
    end else begin
      hot_limit_pulse_ff <= 1'b0;
      if (hot_rise) begin
        hot_exceeded_ff <= 1'b0;
      end else if (hot_active && !hot_exceeded_ff &&
                   hot_duration_timer_ff > limit_mask_ff[MAH_TIMER_W-1:0]) begin
        hot_exceeded_ff <= 1'b1;
        hot_limit_pulse_ff <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Tach measurement pacing

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tach_step_ff <= '0;
      tach_ticks_ff <= 4'h0;
      tach_strobe_ff <= 1'b0;
    end else begin
      tach_strobe_ff <= 1'b0;
      if (tach_step_ff == STEP_LAST) begin
        tach_step_ff <= '0;
        // Shortening the period mid-count takes effect on the next step
        if (tach_ticks_ff + 4'h1 >=
            (cfg_ff[MAH_CFG_FAST] ? MAH_TACH_FAST_STEPS : MAH_TACH_SLOW_STEPS)) begin
          tach_ticks_ff <= 4'h0;
          tach_strobe_ff <= 1'b1;
        end else begin
          tach_ticks_ff <= tach_ticks_ff + 4'h1;
        end
      end else begin
        tach_step_ff <= tach_step_ff + STEP_W'(1);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Alert

  logic [7:0] two_masked;
  logic hot_events;
  logic alert_any;

  always_comb begin
    two_masked = status_two_in & ~mask_two_ff;
    // Fan four fault pin is gone when it carries the hot input
    if (cfg_ff[MAH_CFG_HOT_SEL]) begin
      two_masked[MAH_M2_FAN4_HOT] = hot_exceeded_ff && !mask_two_ff[MAH_M2_FAN4_HOT];
    end else begin
      two_masked[MAH_M2_FAN4_HOT] = status_two_in[MAH_M2_FAN4_HOT] &&
                                    !mask_two_ff[MAH_M2_FAN4_HOT];
    end
  end

  assign hot_events = (hot_release_flag_ff && !limit_mask_ff[MAH_HOT_RELEASE]) ||
                      (hot_assert_flag_ff && !limit_mask_ff[MAH_HOT_ASSERT]);
  assign alert_any = |(status_one_in & ~mask_one_ff[6:0]) ||
                     (|two_masked && !mask_one_ff[MAH_M1_ALL_TWO]) ||
                     hot_events;

  // Open-drain shared pin: alert or pass-through of the second PWM
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pin_drive_low_ff <= 1'b0;
    end else if (cfg_ff[MAH_CFG_ALERT]) begin
      pin_drive_low_ff <= alert_any;
    end else begin
      pin_drive_low_ff <= !pwm_two_drive_in;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read port

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_ff <= 8'h00;
    end else if (rd_hit) begin
      if (reg_addr_in == MAH_ADDR_MASK_ONE) begin
        rdata_ff <= mask_one_ff;
      end else if (reg_addr_in == MAH_ADDR_MASK_TWO) begin
        rdata_ff <= mask_two_ff;
      end else if (reg_addr_in == MAH_ADDR_LOW_VOLTS) begin
        rdata_ff <= low_hold[0];
      end else if (reg_addr_in == MAH_ADDR_LOW_TEMPS) begin
        rdata_ff <= low_hold[1];
      end else if (reg_addr_in == MAH_ADDR_PIN_TACH_CFG) begin
        rdata_ff <= cfg_ff;
      end else if (reg_addr_in == MAH_ADDR_HOT_STATUS) begin
        rdata_ff <= {hot_assert_flag_ff, hot_release_flag_ff, hot_duration_timer_ff};
      end else if (reg_addr_in == MAH_ADDR_HOT_LIMIT_MASK) begin
        rdata_ff <= limit_mask_ff;
      end else if (reg_addr_in == MAH_ADDR_PULSES) begin
        rdata_ff <= pulses_ff;
      end else if (reg_addr_in == MAH_ADDR_TEST_ONE) begin
        rdata_ff <= test_one_ff;
      end else if (reg_addr_in == MAH_ADDR_TEST_TWO) begin
        rdata_ff <= test_two_ff;
      end else begin
        rdata_ff <= 8'h00;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign reg_rdata_out = rdata_ff;
  assign alert_pin_out = 1'b0;
  assign alert_pin_oe_n_out = !pin_drive_low_ff;
  assign alert_active_out = pin_drive_low_ff && cfg_ff[MAH_CFG_ALERT];
  assign hot_limit_exceeded_out = hot_limit_pulse_ff;
  assign fan_ctrl_out.full_speed = cfg_ff[MAH_CFG_BOOST] && hot_state_ff == MAH_HOT_ON;
  assign fan_ctrl_out.fast_tach = cfg_ff[MAH_CFG_FAST];
  assign fan_ctrl_out.continuous_tach = cfg_ff[MAH_CFG_CONT_LO +: 4];
  assign fan_ctrl_out.tach_strobe = tach_strobe_ff;
  assign pulses_per_rev_out = pulses_ff;
  assign factory_test_one_out = test_one_ff;
  assign factory_test_two_out = test_two_ff;

endmodule : mah_regs

//--- verification/mah_regs_properties.sv
`timescale 1ns/1ps
module mah_regs_properties
  import mah_pkg::*;
#(
  parameter int HOT_STEP_CYCLES = 8
) (
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic config_lock_in,
  input wire logic [7:0] low_bits_volts_in,
  input wire logic [1:0] freeze_out,
  input wire logic fourth_tach_pin_in,
  input wire logic hot_limit_exceeded_out,
  input wire mah_pkg::mah_fan_ctrl_type fan_ctrl_out,
  input wire logic [7:0] pulses_per_rev_out,
  input wire logic [7:0] factory_test_one_out
);
  logic [7:0] cfg_ff;
  // Shadow of the config register, which has no output port of its own
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cfg_ff <= 8'h00;
    end else if (reg_wr_in && reg_addr_in == MAH_ADDR_PIN_TACH_CFG) begin
      cfg_ff <= reg_wdata_in;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!arst_n_in);
  AST_FRZ_SET: assert property (reg_rd_in && reg_addr_in == MAH_ADDR_LOW_VOLTS
    |=> freeze_out[0]) else $error("Volts group not frozen");
  AST_FRZ_HOLD: assert property (freeze_out[1] && !(reg_rd_in && reg_addr_in[7:2] == 6'h09)
    |=> freeze_out[1]) else $error("Temps group freeze lost");
  AST_LOW: assert property (reg_rd_in && reg_addr_in == MAH_ADDR_LOW_VOLTS && !freeze_out[0]
    && !$past(freeze_out[0])
    |=> reg_rdata_out == $past(low_bits_volts_in, 2)) else $error("Volts low bits wrong");
  AST_CFG: assert property (reg_wr_in && reg_addr_in == MAH_ADDR_PIN_TACH_CFG
    |=> {fan_ctrl_out.continuous_tach, fan_ctrl_out.fast_tach} == 5'($past(reg_wdata_in) >> 3))
    else $error("Tach controls wrong");
  AST_BOOST: assert property (cfg_ff[1] && $fell(fourth_tach_pin_in)
    |=> fan_ctrl_out.full_speed == cfg_ff[2]) else $error("Full speed wrong");
  AST_LIM: assert property (hot_limit_exceeded_out |=> !hot_limit_exceeded_out)
    else $error("Limit pulse too long");
  AST_PPR: assert property (reg_wr_in && reg_addr_in == MAH_ADDR_PULSES
    |=> pulses_per_rev_out == $past(reg_wdata_in)) else $error("Pulses not written");
  AST_LOCK: assert property (config_lock_in && reg_wr_in && reg_addr_in == MAH_ADDR_TEST_ONE
    |=> $stable(factory_test_one_out)) else $error("Locked test reg changed");
endmodule : mah_regs_properties
bind mah_regs mah_regs_properties #(
  .HOT_STEP_CYCLES(HOT_STEP_CYCLES)
) u_props (
  .clock_in(clock_in),
  .arst_n_in(arst_n_in),
  .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in),
  .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out),
  .config_lock_in(config_lock_in),
  .low_bits_volts_in(low_bits_volts_in),
  .freeze_out(freeze_out),
  .fourth_tach_pin_in(fourth_tach_pin_in),
  .hot_limit_exceeded_out(hot_limit_exceeded_out),
  .fan_ctrl_out(fan_ctrl_out),
  .pulses_per_rev_out(pulses_per_rev_out),
  .factory_test_one_out(factory_test_one_out)
);

//--- verification/mah_hot_source.sv
`timescale 1ns/1ps
module mah_hot_source (
  input wire logic clock_in,
  input wire logic hot_req_in,
  output logic hot_pin_n_out = 1'b1
);
  // Active low; pulled high whenever the processor is not hot
  always_ff @(posedge clock_in) begin
    hot_pin_n_out <= !hot_req_in;
  end
endmodule : mah_hot_source

//--- verification/mah_regs_bench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; \
  $display("Error at %0t: got %0h expected %0h", $time, (g), (e)); end end
module mah_regs_bench;
  import mah_pkg::*;
  localparam int STEP = 8;
  logic clock_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, lv = 8'h00, lt = 8'h00, s2 = 8'h00;
  logic wr = 1'b0, rd = 1'b0, lock = 1'b0, pwm = 1'b1, hot_req = 1'b0;
  logic [6:0] s1 = 7'h00;
  logic [7:0] rdata, ppr;
  logic [1:0] frz;
  logic pin_n, oe_n, alert, lim, pin_lvl;
  mah_fan_ctrl_type fan;
  int mismatches = 0, compares = 0, cycles = 0, lim_cnt = 0, cnt = 0, gap = 0;
  //////////////////////////////////////////////////////////////////////////////
  mah_hot_source hot_src (.clock_in(clock_in), .hot_req_in(hot_req), .hot_pin_n_out(pin_n));
  mah_regs #(.HOT_STEP_CYCLES(STEP)) dut (
    .clock_in(clock_in), .arst_n_in(arst_n_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .config_lock_in(lock),
    .low_bits_volts_in(lv), .low_bits_temps_in(lt), .freeze_out(frz), .status_one_in(s1),
    .status_two_in(s2), .fourth_tach_pin_in(pin_n), .pwm_two_drive_in(pwm),
    .alert_pin_out(pin_lvl), .alert_pin_oe_n_out(oe_n), .alert_active_out(alert),
    .hot_limit_exceeded_out(lim), .fan_ctrl_out(fan), .pulses_per_rev_out(ppr),
    .factory_test_one_out(), .factory_test_two_out()
  );
  initial begin
    forever #4 clock_in = ~clock_in;
  end
  // Run needs under 3000 cycles
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_of_test();
    end
    if (lim === 1'b1) begin
      lim_cnt++;
    end
    if (fan.tach_strobe === 1'b1) begin
      gap = cnt;
      cnt = 1;
    end else begin
      cnt++;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
  endtask : tick
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock_in);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e, input bit chk = 1'b1);
    @(posedge clock_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock_in);
    rd <= 1'b0;
    #1;
    if (chk) begin
      `CHK(rdata, e)
    end
  endtask : rd_reg
  task automatic t_regs();
    logic [7:0] a[9] = '{8'h74, 8'h75, 8'h78, 8'h79, 8'h7A, 8'h7B, 8'h7C, 8'h7E, 8'h7F};
    foreach (a[i]) begin
      rd_reg(a[i], a[i] == MAH_ADDR_PULSES ? MAH_RST_PULSES : 8'h00);
    end
    `CHK(ppr, MAH_RST_PULSES)
    wr_reg(MAH_ADDR_MASK_ONE, 8'hFF);
    rd_reg(MAH_ADDR_MASK_ONE, 8'h7F);
    wr_reg(MAH_ADDR_MASK_TWO, 8'hFF);
    rd_reg(MAH_ADDR_MASK_TWO, 8'hFD);
    wr_reg(MAH_ADDR_PULSES, 8'hE4);
    rd_reg(MAH_ADDR_PULSES, 8'hE4);
    `CHK(ppr, 8'hE4)
    wr_reg(MAH_ADDR_TEST_ONE, 8'h5A);
    lock <= 1'b1;
    wr_reg(MAH_ADDR_TEST_ONE, 8'hC3);
    rd_reg(MAH_ADDR_TEST_ONE, 8'h5A);
    wr_reg(MAH_ADDR_TEST_TWO, 8'h77);
    rd_reg(MAH_ADDR_TEST_TWO, 8'h00);
    $display("Register test done");
  endtask : t_regs
  task automatic t_freeze();
    @(posedge clock_in);
    lv <= 8'hA5;
    lt <= 8'h3C;
    for (int g = 0; g < 2; g++) begin
      rd_reg(8'(8'h76 + g), g ? 8'h3C : 8'hA5);
      @(posedge clock_in);
      lv <= g ? lv : 8'h5A;
      lt <= g ? 8'hC3 : lt;
      rd_reg(8'(8'h76 + g), g ? 8'h3C : 8'hA5);
      for (int j = 0; j < 4; j++) begin
        `CHK(frz[g], 1'b1)
        rd_reg(8'(8'h20 + 4 * g + j), 8'h00, 1'b0);
      end
      `CHK(frz[g], 1'b0)
      rd_reg(8'(8'h76 + g), g ? 8'hC3 : 8'h5A);
    end
    $display("Freeze test done");
  endtask : t_freeze
  task automatic t_tach();
    wr_reg(MAH_ADDR_PIN_TACH_CFG, 8'hF8);
    tick(20 * STEP);
    `CHK(fan.continuous_tach, 4'hF)
    `CHK(gap, 2 * STEP)
    wr_reg(MAH_ADDR_PIN_TACH_CFG, 8'h50);
    tick(20 * STEP);
    `CHK(fan.continuous_tach, 4'h5)
    `CHK(gap, 8 * STEP)
    $display("Tach test done");
  endtask : t_tach
  task automatic t_hot();
    int n0;
    wr_reg(MAH_ADDR_MASK_ONE, 8'h00);
    wr_reg(MAH_ADDR_MASK_TWO, 8'hFF);
    wr_reg(MAH_ADDR_HOT_LIMIT_MASK, 8'hC2);
    wr_reg(MAH_ADDR_PIN_TACH_CFG, 8'h07);
    n0 = lim_cnt;
    hot_req <= 1'b1;
    tick(3);
    `CHK(fan.full_speed, 1'b1)
    tick(3 * STEP + STEP / 2 - 3);
    `CHK(alert, 1'b0)
    hot_req <= 1'b0;
    tick(4);
    `CHK(fan.full_speed, 1'b0)
    `CHK(alert, 1'b0)
    `CHK(lim_cnt - n0, 1)
    rd_reg(MAH_ADDR_HOT_STATUS, 8'hC3);
    rd_reg(MAH_ADDR_HOT_STATUS, 8'h03);
    // Flags are gone; only the kept limit overrun can raise the alert now
    wr_reg(MAH_ADDR_MASK_TWO, 8'hDF);
    tick(3);
    `CHK(alert, 1'b1)
    wr_reg(MAH_ADDR_HOT_LIMIT_MASK, 8'h02);
    hot_req <= 1'b1;
    tick(5);
    `CHK(alert, 1'b1)
    `CHK(oe_n, 1'b0)
    hot_req <= 1'b0;
    tick(4);
    rd_reg(MAH_ADDR_HOT_STATUS, 8'hC0);
    tick(3);
    `CHK(alert, 1'b0)
    $display("Processor hot test done");
  endtask : t_hot
  task automatic t_alert();
    wr_reg(MAH_ADDR_PIN_TACH_CFG, 8'h01);
    for (int i = 0; i < 15; i++) begin
      s2 <= i < 8 ? 8'(1 << i) : 8'h00;
      s1 <= i < 8 ? 7'h00 : 7'(1 << (i - 8));
      wr_reg(MAH_ADDR_MASK_ONE, 8'hFF);
      wr_reg(MAH_ADDR_MASK_TWO, 8'hFF);
      tick(3);
      `CHK(alert, i == 1)
      wr_reg(i < 8 ? MAH_ADDR_MASK_TWO : MAH_ADDR_MASK_ONE, ~8'(1 << (i % 8)));
      tick(3);
      `CHK(alert, 1'b1)
    end
    wr_reg(MAH_ADDR_PIN_TACH_CFG, 8'h00);
    pwm <= 1'b0;
    tick(3);
    `CHK(oe_n, 1'b0)
    `CHK(pin_lvl, 1'b0)
    pwm <= 1'b1;
    tick(3);
    `CHK(oe_n, 1'b1)
    $display("Alert test done");
  endtask : t_alert
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    tick(2);
    arst_n_in <= 1'b1;
    t_regs();
    t_freeze();
    t_tach();
    t_hot();
    t_alert();
    end_of_test();
  end
endmodule : mah_regs_bench
